// *** shared/dcbr_consts.vh ***
`ifndef DCBR_CONSTS_VH
`define DCBR_CONSTS_VH

`define DCBR_OFS_CTRL_A      8'h00
`define DCBR_OFS_CTRL_B      8'h04
`define DCBR_OFS_AREA_WIDTH  8'h08
`define DCBR_OFS_TIMER_CTL   8'h0c
`define DCBR_OFS_COUNTER     8'h10
`define DCBR_OFS_MATCH       8'h14
`define DCBR_OFS_STATUS      8'h18

`define DCBR_A_BURST         0
`define DCBR_A_HOLD          1
`define DCBR_A_SELF_REFRESH  2
`define DCBR_A_PIN_ON        3

`define DCBR_B_PIN_CHOICE    0
`define DCBR_B_MUX_LO        1
`define DCBR_B_MUX_HI        2
`define DCBR_B_CBR_ON        3
`define DCBR_B_PRECHARGE     4
`define DCBR_B_STRETCH       5

`define DCBR_RST_CTRL_A      4'h0
`define DCBR_RST_CTRL_B      6'h00
`define DCBR_RST_AREA_WIDTH  4'h0
`define DCBR_RST_TIMER_CTL   3'h0
`define DCBR_RST_COUNTER     8'h00
`define DCBR_RST_MATCH       8'hff

`define DCBR_ROW_LOW_BASE    5'h09
`define DCBR_ROW_TOP_1M      5'h13
`define DCBR_ROW_TOP_16M     5'h17
`define DCBR_MUX_ILLEGAL     2'h3

`endif

// *** hw/dcbr_ctrl.v ***
`include "dcbr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dcbr_ctrl #(
  parameter AW = 24,
  parameter CW = 8
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire          acc_req_i,
  input  wire          acc_dram_i,
  input  wire [1:0]    acc_area_i,
  input  wire [AW-1:0] acc_addr_i,
  input  wire [1:0]    acc_bytes_i,
  input  wire          acc_write_i,
  input  wire [1:0]    acc_wait_i,
  input  wire          mode_16m_i,
  input  wire          bus_release_i,
  input  wire          standby_i,
  output reg           acc_done_o,
  output reg           bus_released_o,
  output reg           dram_we_n_o,
  output reg           port_b_pin4_n_o,
  output reg           port_b_pin5_n_o,
  output reg           high_write_strobe_n_o,
  output reg           low_write_strobe_n_o,
  output reg           port_b_pin5_free_o,
  output reg  [3:0]    area_row_strobe_n_o,
  output reg           refresh_indicator_pin_n_o
);

  localparam [4:0] S_IDLE  = 5'h00;
  localparam [4:0] S_PRE   = 5'h01;
  localparam [4:0] S_PRE2  = 5'h02;
  localparam [4:0] S_ROW   = 5'h03;
  localparam [4:0] S_COL1  = 5'h04;
  localparam [4:0] S_WAIT  = 5'h05;
  localparam [4:0] S_COL2  = 5'h06;
  localparam [4:0] S_TI    = 5'h07;
  localparam [4:0] S_RP    = 5'h08;
  localparam [4:0] S_RPX   = 5'h09;
  localparam [4:0] S_R1    = 5'h0a;
  localparam [4:0] S_RW    = 5'h0b;
  localparam [4:0] S_R2    = 5'h0c;
  localparam [4:0] S_STBYC = 5'h0d;
  localparam [4:0] S_STBY  = 5'h0e;
  localparam [4:0] S_REL   = 5'h0f;
  localparam [4:0] S_GAP   = 5'h10;

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  reg  [3:0]    ctrl_a_r;
  reg  [5:0]    ctrl_b_r;
  reg  [3:0]    area_width_r;
  reg  [2:0]    clk_sel_r;
  reg  [CW-1:0] counter_r;
  reg  [CW-1:0] match_r;
  reg  [4:0]    state_r;
  reg           row_open_r;
  reg  [1:0]    open_area_r;
  reg  [AW-1:0] open_row_r;
  reg           ref_pend_r;

  wire          wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes commit on the edge where the master samples ack high
  wire          wb_wr     = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire          burst_on  = ctrl_a_r[`DCBR_A_BURST];
  wire          hold_on   = ctrl_a_r[`DCBR_A_HOLD];
  wire          srf_on    = ctrl_a_r[`DCBR_A_SELF_REFRESH];
  wire          pin_on    = ctrl_a_r[`DCBR_A_PIN_ON];
  wire          choice    = ctrl_b_r[`DCBR_B_PIN_CHOICE];
  wire [1:0]    mux       = {ctrl_b_r[`DCBR_B_MUX_HI], ctrl_b_r[`DCBR_B_MUX_LO]};
  wire          cbr_on    = ctrl_b_r[`DCBR_B_CBR_ON];
  wire          precharge = ctrl_b_r[`DCBR_B_PRECHARGE];
  wire          stretch   = ctrl_b_r[`DCBR_B_STRETCH];
  wire          refreshing = (state_r >= S_RP) && (state_r <= S_R2);
  wire          self_ref  = (state_r == S_STBYC) || (state_r == S_STBY);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_a_r     <= `DCBR_RST_CTRL_A;
      ctrl_b_r     <= `DCBR_RST_CTRL_B;
      area_width_r <= `DCBR_RST_AREA_WIDTH;
      clk_sel_r    <= `DCBR_RST_TIMER_CTL;
      match_r      <= `DCBR_RST_MATCH;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_wr)
      begin
        case (wb_adr_i)
          `DCBR_OFS_CTRL_A:     ctrl_a_r     <= wb_dat_i[3:0];
          `DCBR_OFS_CTRL_B:     ctrl_b_r     <= wb_dat_i[5:0];
          `DCBR_OFS_AREA_WIDTH: area_width_r <= wb_dat_i[3:0];
          `DCBR_OFS_TIMER_CTL:  clk_sel_r    <= wb_dat_i[2:0];
          `DCBR_OFS_MATCH:      match_r      <= wb_dat_i[CW-1:0];
          default:              ;
        endcase
      end
      // Unmapped offsets read zero; writes there are dropped
      case (wb_adr_i)
        `DCBR_OFS_CTRL_A:     wb_dat_o <= {28'h0000000, ctrl_a_r};
        `DCBR_OFS_CTRL_B:     wb_dat_o <= {26'h0000000, ctrl_b_r};
        `DCBR_OFS_AREA_WIDTH: wb_dat_o <= {28'h0000000, area_width_r};
        `DCBR_OFS_TIMER_CTL:  wb_dat_o <= {29'h0000000, clk_sel_r};
        `DCBR_OFS_COUNTER:    wb_dat_o <= {{(32-CW){1'b0}}, counter_r};
        `DCBR_OFS_MATCH:      wb_dat_o <= {{(32-CW){1'b0}}, match_r};
        `DCBR_OFS_STATUS:     wb_dat_o <= {27'h0000000, bus_released_o, self_ref,
                                           ref_pend_r, refreshing, row_open_r};
        default:              wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Refresh timer

  reg  [11:0] pre_r;
  reg  [11:0] pre_mask;

  always @*
  begin
    case (clk_sel_r)
      3'h1:    pre_mask = 12'h001;
      3'h2:    pre_mask = 12'h007;
      3'h3:    pre_mask = 12'h01f;
      3'h4:    pre_mask = 12'h07f;
      3'h5:    pre_mask = 12'h1ff;
      3'h6:    pre_mask = 12'h7ff;
      default: pre_mask = 12'hfff;
    endcase
  end

  wire tick    = (clk_sel_r != 3'h0) && ((pre_r & pre_mask) == pre_mask);
  wire cmatch  = tick && (counter_r == match_r);
  wire ref_evt = cmatch && cbr_on;
  wire ref_take;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r      <= 12'h000;
      counter_r  <= `DCBR_RST_COUNTER;
      ref_pend_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_r + 12'h001;
      // Match clear beats a software write; a write beats an increment
      if (cmatch)
        counter_r <= {CW{1'b0}};
      else if (wb_wr && (wb_adr_i == `DCBR_OFS_COUNTER))
        counter_r <= wb_dat_i[CW-1:0];
      else if (tick)
        counter_r <= counter_r + {{(CW-1){1'b0}}, 1'b1};
      // A request already waiting or a cycle in flight swallows new ones
      if (ref_take)
        ref_pend_r <= 1'b0;
      else if (ref_evt && !ref_pend_r && !refreshing)
        ref_pend_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Row compare

  wire          acc_w8  = area_width_r[acc_area_i];
  wire [4:0]    row_lo  = `DCBR_ROW_LOW_BASE + {3'h0, mux} - {4'h0, acc_w8};
  wire [4:0]    row_top = mode_16m_i ? `DCBR_ROW_TOP_16M : `DCBR_ROW_TOP_1M;
  wire [AW-1:0] row_mask;

  genvar gi;
  generate
    for (gi = 0; gi < AW; gi = gi + 1)
    begin : g_mask
      assign row_mask[gi] = (gi >= row_lo) && (gi <= row_top);
    end
  endgenerate

  wire [AW-1:0] acc_row = acc_addr_i & row_mask;
  // Unchanged row with the row strobe still low means a page hit
  wire          burst_hit = burst_on && row_open_r && (mux != `DCBR_MUX_ILLEGAL) &&
                            (open_area_r == acc_area_i) && (acc_row == open_row_r);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  reg  [1:0] cur_area_r;
  reg        cur_w8_r;
  reg  [1:0] cur_bytes_r;
  reg        cur_write_r;
  reg  [1:0] wait_cnt_r;
  reg        last_dram_r;

  assign ref_take = (state_r == S_IDLE) && !(standby_i && srf_on) && !bus_release_i &&
                    ref_pend_r && cbr_on;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r     <= S_IDLE;
      row_open_r  <= 1'b0;
      open_area_r <= 2'h0;
      open_row_r  <= {AW{1'b0}};
      cur_area_r  <= 2'h0;
      cur_w8_r    <= 1'b0;
      cur_bytes_r <= 2'h0;
      cur_write_r <= 1'b0;
      wait_cnt_r  <= 2'h0;
      last_dram_r <= 1'b0;
      acc_done_o  <= 1'b0;
    end
    else
    begin
      acc_done_o <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (standby_i && srf_on)
          begin
            row_open_r <= 1'b0;
            state_r    <= S_STBYC;
          end
          else if (bus_release_i)
          begin
            row_open_r <= 1'b0;
            state_r    <= S_REL;
          end
          else if (ref_take)
          begin
            row_open_r <= 1'b0;
            state_r    <= S_RP;
          end
          else if (acc_req_i && acc_dram_i)
          begin
            cur_area_r  <= acc_area_i;
            cur_w8_r    <= acc_w8;
            cur_bytes_r <= acc_bytes_i;
            cur_write_r <= acc_write_i;
            wait_cnt_r  <= acc_wait_i;
            open_row_r  <= acc_row;
            open_area_r <= acc_area_i;
            if (burst_hit)
              state_r <= S_COL1;
            else
            begin
              row_open_r <= 1'b0;
              state_r    <= S_PRE;
            end
          end
          else if (acc_req_i)
          begin
            if (!hold_on || !burst_on)
              row_open_r <= 1'b0;
            last_dram_r <= 1'b0;
            state_r     <= (last_dram_r && choice) ? S_TI : S_GAP;
          end
          else if (!burst_on || (!hold_on && !last_dram_r))
            row_open_r <= 1'b0;
        end
        S_PRE:
        begin
          if (precharge)
            state_r <= S_PRE2;
          else
          begin
            row_open_r <= 1'b1;
            state_r    <= S_ROW;
          end
        end
        S_PRE2:
        begin
          row_open_r <= 1'b1;
          state_r    <= S_ROW;
        end
        S_ROW:   state_r <= S_COL1;
        S_COL1:  state_r <= (wait_cnt_r != 2'h0) ? S_WAIT : S_COL2;
        S_WAIT:
        begin
          wait_cnt_r <= wait_cnt_r - 2'h1;
          if (wait_cnt_r == 2'h1)
            state_r <= S_COL2;
        end
        S_COL2:
        begin
          last_dram_r <= 1'b1;
          if (!burst_on)
            row_open_r <= 1'b0;
          state_r <= S_GAP;
        end
        S_TI:    state_r <= S_GAP;
        // Refresh length depends only on the two option bits
        S_RP:    state_r <= precharge ? S_RPX : S_R1;
        S_RPX:   state_r <= S_R1;
        S_R1:    state_r <= stretch ? S_RW : S_R2;
        S_RW:    state_r <= S_R2;
        S_R2:
        begin
          last_dram_r <= 1'b0;
          state_r     <= S_IDLE;
        end
        S_STBYC: state_r <= S_STBY;
        S_STBY:
        begin
          if (!standby_i)
            state_r <= S_IDLE;
        end
        S_REL:
        begin
          last_dram_r <= 1'b0;
          if (!bus_release_i)
            state_r <= S_IDLE;
        end
        S_GAP:   state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
      if ((state_r == S_COL2) || ((state_r == S_IDLE) && acc_req_i && !acc_dram_i &&
          !(standby_i && srf_on) && !bus_release_i && !ref_take && !(last_dram_r && choice))
          || (state_r == S_TI))
        acc_done_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so every output leaves a flip-flop

  wire col_on  = (state_r == S_COL1) || (state_r == S_WAIT) || (state_r == S_COL2);
  wire ref_cas = (state_r == S_RPX) || (state_r == S_R1) || (state_r == S_RW) ||
                 (state_r == S_R2);
  wire ref_ras = (state_r == S_RW) || (state_r == S_R2);
  wire up_on   = (col_on && (cur_w8_r || cur_bytes_r[1])) || ref_cas || self_ref;
  wire lo_on   = (col_on && !cur_w8_r && cur_bytes_r[0]) || ref_cas || self_ref;
  wire all_ras = ref_ras || (state_r == S_STBY);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_released_o            <= 1'b0;
      dram_we_n_o               <= 1'b1;
      port_b_pin4_n_o           <= 1'b1;
      port_b_pin5_n_o           <= 1'b1;
      high_write_strobe_n_o     <= 1'b1;
      low_write_strobe_n_o      <= 1'b1;
      port_b_pin5_free_o        <= 1'b0;
      area_row_strobe_n_o       <= 4'hf;
      refresh_indicator_pin_n_o <= 1'b1;
    end
    else
    begin
      bus_released_o        <= (state_r == S_REL);
      dram_we_n_o           <= ~(cur_write_r && (state_r >= S_ROW) && (state_r <= S_COL2));
      port_b_pin4_n_o       <= ~(up_on && !choice);
      // Pin 5 stays a port pin with no 16-bit area, refresh included
      port_b_pin5_n_o       <= ~(lo_on && !choice && (area_width_r != 4'hf));
      high_write_strobe_n_o <= ~(up_on && choice);
      low_write_strobe_n_o  <= ~(lo_on && choice);
      port_b_pin5_free_o    <= (area_width_r == 4'hf) && !choice;
      if (all_ras)
        area_row_strobe_n_o <= 4'h0;
      else if (row_open_r)
        area_row_strobe_n_o <= ~(4'h1 << open_area_r);
      else
        area_row_strobe_n_o <= 4'hf;
      // Refresh and self-refresh both count as refresh on the indicator
      refresh_indicator_pin_n_o <= ~(pin_on && (refreshing || self_ref));
    end
  end

endmodule // dcbr_ctrl

`default_nettype wire

// *** dv/dcbr_dram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbr_dram_model (
  input  wire logic       clk_i,
  input  wire logic       upper_col_n_i,
  input  wire logic [3:0] row_n_i,
  output var  logic [7:0] cbr_cnt_o
);
  logic [3:0] row_q = 4'hf;
  initial cbr_cnt_o = 8'h00;
  // Observer only: the block has no data pins to answer on
  always @(posedge clk_i)
  begin
    row_q <= row_n_i;
    // Row falling while column already low is a refresh, not an access
    if (((row_q & ~row_n_i) != 4'h0) && !upper_col_n_i)
      cbr_cnt_o <= cbr_cnt_o + 8'h01;
  end
endmodule // dcbr_dram_model
`default_nettype wire

// *** dv/dcbr_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbr_ctrl_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       standby_i,
  input wire logic       bus_released_o,
  input wire logic       port_b_pin4_n_o,
  input wire logic       port_b_pin5_n_o,
  input wire logic       high_write_strobe_n_o,
  input wire logic       port_b_pin5_free_o,
  input wire logic [3:0] area_row_strobe_n_o,
  input wire logic       refresh_indicator_pin_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Standby is excluded: self-refresh also pulls the indicator low
  sequence s_rf_fall;
    $fell(refresh_indicator_pin_n_o) && !standby_i;
  endsequence
  sequence s_rf_hold;
    !refresh_indicator_pin_n_o [*3];
  endsequence
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_pin_pair_excl: assert property (!(!port_b_pin4_n_o && !high_write_strobe_n_o))
    else $error("strobe on both pairs");
  a_pin5_left_free: assert property
    (port_b_pin5_free_o |-> port_b_pin5_n_o)
    else $error("free pin driven");
  a_refresh_min_len: assert property (s_rf_fall |-> s_rf_hold)
    else $error("refresh too short");
  a_refresh_max_len: assert property (s_rf_fall |-> ##[3:5] refresh_indicator_pin_n_o)
    else $error("refresh too long");
  a_release_rows_up: assert property
    (bus_released_o && $past(bus_released_o) |-> area_row_strobe_n_o == 4'hf)
    else $error("row open while released");
  a_no_refresh_released: assert property
    ($fell(refresh_indicator_pin_n_o) |-> !bus_released_o)
    else $error("refresh without bus");
  a_standby_exit_high: assert property
    ($fell(standby_i) && area_row_strobe_n_o == 4'h0 |->
      ##[1:4] (area_row_strobe_n_o == 4'hf && port_b_pin4_n_o && high_write_strobe_n_o))
    else $error("strobes low after standby");
endmodule // dcbr_ctrl_properties
bind dcbr_ctrl dcbr_ctrl_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .standby_i(standby_i), .bus_released_o(bus_released_o),
  .port_b_pin4_n_o(port_b_pin4_n_o), .port_b_pin5_n_o(port_b_pin5_n_o),
  .high_write_strobe_n_o(high_write_strobe_n_o), .port_b_pin5_free_o(port_b_pin5_free_o),
  .area_row_strobe_n_o(area_row_strobe_n_o),
  .refresh_indicator_pin_n_o(refresh_indicator_pin_n_o)
);
`default_nettype wire

// *** dv/dcbr_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbr_ctrl_tb_top;
  localparam int FULL = 6;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, acc_req_i = 0;
  logic        acc_dram_i = 0, mode_16m_i = 0, bus_release_i = 0, standby_i = 0;
  logic        wb_ack_o, acc_done_o, bus_released_o, pin4_n, pin5_n, hw_n, lw_n, free, rf_n;
  logic [1:0]  acc_bytes_i = 0, acc_wait_i = 0;
  logic        acc_write_i = 0, we_n, we_seen;
  logic [3:0]  row_n, seen;
  logic [7:0]  wb_adr_i = 0, cbr_cnt, c0;
  logic [23:0] acc_addr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  int          err_total = 0, checks = 0, n, rf_run = 0, rf_len = 0, cyc = 0, t0 = 0, t_gap = 0;
  // Row: choice, all 8-bit, bytes, strobes seen {pin4, pin5, high, low}
  logic [7:0]  pin_tab [5] = '{8'h3c, 8'h14, 8'h68, 8'hb3, 8'he2};
  logic [23:0] bd [5] = '{24'h000100, 24'h000200, 24'h000100, 24'h100000, 24'h100000};
  int          bx [5] = '{4, 6, 6, 4, 6};
  logic [4:0]  bw = 5'h04, bm = 5'h10;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  always #5 clk_i = ~clk_i;
  dcbr_ctrl DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_req_i(acc_req_i), .acc_dram_i(acc_dram_i), .acc_area_i(2'h0),
    .acc_addr_i(acc_addr_i), .acc_bytes_i(acc_bytes_i), .acc_write_i(acc_write_i),
    .acc_wait_i(acc_wait_i), .mode_16m_i(mode_16m_i), .bus_release_i(bus_release_i),
    .standby_i(standby_i), .acc_done_o(acc_done_o), .bus_released_o(bus_released_o),
    .dram_we_n_o(we_n), .port_b_pin4_n_o(pin4_n), .port_b_pin5_n_o(pin5_n),
    .high_write_strobe_n_o(hw_n), .low_write_strobe_n_o(lw_n), .port_b_pin5_free_o(free),
    .area_row_strobe_n_o(row_n), .refresh_indicator_pin_n_o(rf_n));
  dcbr_dram_model u_dram (.clk_i(clk_i), .upper_col_n_i(pin4_n & hw_n), .row_n_i(row_n),
    .cbr_cnt_o(cbr_cnt));
  ////////////////////////////////////////
  // Length of the last indicator pulse and spacing of pulse starts
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (!rf_n && rf_run == 0)
    begin
      t_gap <= cyc - t0;
      t0 <= cyc;
    end
    if (!rf_n)
      rf_run <= rf_run + 1;
    else if (rf_run != 0)
    begin
      rf_len <= rf_run;
      rf_run <= 0;
    end
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      stop_test();
    end
  endtask
  // Counts edges from raising the request to seeing done
  task automatic acc(logic d, logic [23:0] a, logic [1:0] b, logic [1:0] w);
    @(posedge clk_i);
    acc_req_i <= 1'b1;
    acc_dram_i <= d;
    acc_addr_i <= a;
    acc_bytes_i <= b;
    acc_wait_i <= w;
    n = 0;
    seen = 4'h0;
    we_seen = 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
      seen |= ~{pin4_n, pin5_n, hw_n, lw_n};
      we_seen |= !we_n;
    end while (acc_done_o !== 1'b1 && n < 60);
    acc_req_i <= 1'b0;
    if (n >= 60)
    begin
      err_total++;
      stop_test();
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (pin_tab[i])
    begin
      wb(1, 8'h04, {31'h0, pin_tab[i][7]});
      wb(1, 8'h08, {28'h0, {4{pin_tab[i][6]}}});
      acc(1, 24'h0, pin_tab[i][5:4], 2'h0);
      chk("strobes", seen, pin_tab[i][3:0]);
      chk("pin5 free", free, !pin_tab[i][7] && pin_tab[i][6]);
      chk("read we", we_seen, 1'b0);
    end
    acc_write_i <= 1'b1;
    acc(1, 24'h0, 2'h3, 2'h0);
    chk("write we", we_seen, 1'b1);
    acc_write_i <= 1'b0;
    wb(1, 8'h00, 32'h1);
    wb(1, 8'h04, 32'h8);
    for (int i = 0; i < 5; i++)
    begin
      wb(1, 8'h08, {28'h0, {4{bw[i]}}});
      mode_16m_i <= bm[i];
      acc(0, 24'h0, 2'h3, 2'h0);
      acc(1, 24'h0, 2'h3, 2'h0);
      acc(1, bd[i], 2'h3, 2'h0);
      chk("row compare", n, bx[i]);
    end
    acc(1, 24'h100000, 2'h3, 2'h2);
    chk("burst wait", n, 6);
    acc(0, 24'h0, 2'h3, 2'h0);
    acc(1, 24'h100000, 2'h3, 2'h0);
    chk("up mode", n, FULL);
    wb(1, 8'h00, 32'h3);
    acc(0, 24'h0, 2'h3, 2'h0);
    acc(1, 24'h100000, 2'h3, 2'h0);
    chk("hold mode", n, 4);
    bus_release_i <= 1'b1;
    for (n = 0; n < 20 && bus_released_o !== 1'b1; n++)
      @(posedge clk_i);
    @(posedge clk_i);
    chk("released rows", {n < 20, row_n}, 5'h1f);
    bus_release_i <= 1'b0;
    acc(1, 24'h100000, 2'h3, 2'h0);
    chk("row reopened", n, FULL);
    wb(1, 8'h00, 32'h1);
    for (int c = 0; c < 2; c++)
    begin
      wb(1, 8'h04, c);
      acc(1, 24'h0, 2'h3, 2'h0);
      acc(0, 24'h0, 2'h3, 2'h0);
      chk("idle state", n, 2 + c);
    end
    // Timer loaded before the clock select, so the first interval is clean
    wb(1, 8'h00, 32'h8);
    wb(1, 8'h14, 32'h4);
    wb(1, 8'h10, 32'h0);
    wb(1, 8'h0c, 32'h1);
    acc_wait_i <= 2'h3;
    for (int i = 0; i < 4; i++)
    begin
      wb(1, 8'h04, {26'h0, i[1:0], 4'h8});
      repeat (40) @(posedge clk_i);
      chk("refresh len", rf_len, 3 + i[0] + i[1]);
      chk("refresh gap", t_gap, 10);
    end
    bus_release_i <= 1'b1;
    for (n = 0; n < 20 && bus_released_o !== 1'b1; n++)
      @(posedge clk_i);
    chk("release seen", n < 20, 1'b1);
    c0 = cbr_cnt;
    repeat (40) @(posedge clk_i);
    wb(1, 8'h0c, 32'h0);
    bus_release_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk("held refresh", cbr_cnt, c0 + 8'h01);
    wb(1, 8'h00, 32'hc);
    standby_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("self refresh", {rf_n, pin4_n, row_n}, 6'h00);
    standby_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("standby exit", {rf_n, pin4_n, row_n}, 6'h3f);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1, 8'h1c, 32'hff);
    foreach (ra[i])
    begin
      wb(0, ra[i], 32'h0);
      chk("reset value", rd, (ra[i] == 8'h14) ? 32'hff : 32'h0);
    end
    wb(1, 8'h04, 32'h3b);
    wb(0, 8'h04, 32'h0);
    chk("ctrl b", rd, 32'h3b);
    stop_test();
  end
endmodule // dcbr_ctrl_tb_top
`default_nettype wire
